// ---- asl_led_dev.sv ----
// LED PWM controller end: serial write-only slave, control fields and PWM outputs.
// Assumes the band amplitudes come from logic on the same clock; link pins are async.
//
// The strobed register port and the register offsets were left to the implementer.
module asl_led_dev #(
  parameter int PWM_STEP_FAST = asl_pkg::CLK_HZ / (asl_pkg::PWM_HZ_FAST * asl_pkg::PWM_STEPS),
  parameter int PWM_STEP_60 = asl_pkg::CLK_HZ / (asl_pkg::PWM_HZ_60 * asl_pkg::PWM_STEPS),
  parameter int PWM_STEP_7 = asl_pkg::CLK_HZ / (asl_pkg::PWM_HZ_7 * asl_pkg::PWM_STEPS),
  parameter int PWM_STEP_4 = asl_pkg::CLK_HZ / (asl_pkg::PWM_HZ_4 * asl_pkg::PWM_STEPS),
  parameter int SHUFFLE_CYC = asl_pkg::SHUFFLE_MS * (asl_pkg::CLK_HZ / asl_pkg::MS_PER_S)
) (
  input wire logic clock,
  input wire logic rst_n,
  asl_link_if.dev link,
  input wire logic addr_sel,
  input wire logic [7:0] low_band_amp,
  input wire logic [7:0] mid_band_amp,
  input wire logic [7:0] high_band_amp,
  output logic first_color_output,
  output logic second_color_output,
  output logic third_color_output,
  output logic device_shutdown,
  output logic core_reset_hold,
  output logic [1:0] highpass_cutoff_field,
  output logic [2:0] midband_gain_field,
  output logic [2:0] input_sum_gain_field,
  output logic [5:0] led_current_field
);
  localparam logic [16:0] STEP_F = PWM_STEP_FAST[16:0];
  localparam logic [16:0] STEP_60 = PWM_STEP_60[16:0];
  localparam logic [16:0] STEP_7 = PWM_STEP_7[16:0];
  localparam logic [16:0] STEP_4 = PWM_STEP_4[16:0];
  localparam logic [28:0] SHUF_LAST = 29'(SHUFFLE_CYC - 1);

  // Rotate a channel index by the shuffle offset, modulo three
  function automatic logic [1:0] band_for(input logic [1:0] chan, input logic [1:0] rot);
    logic [2:0] sum;
    sum = {1'b0, chan} + {1'b0, rot};
    return (sum >= 3'h3) ? 2'(sum - 3'h3) : sum[1:0];
  endfunction

  logic [2:0] pin_raw;
  logic [2:0] pin_s;
  logic scl_s;
  logic sda_s;
  logic adr_s;
  logic scl_prev_reg;
  logic sda_prev_reg;
  logic start_det;
  logic stop_det;
  logic scl_rise;
  logic scl_fall;
  logic addr_match;
  logic commit;
  asl_pkg::asl_dev_state_e state_reg, state_next;
  logic [3:0] bit_reg, bit_next;
  logic [7:0] shift_reg, shift_next;
  logic oe_reg, oe_next;
  logic [2:0] mode_reg;
  logic [1:0] pwm_sel_reg;
  logic [1:0] hpf_reg;
  logic [3:0] patt_reg;
  logic [5:0] cur_reg;
  logic [2:0] mid_reg;
  logic [2:0] sum_reg;
  logic wr_mode;
  logic wr_freq;
  logic wr_patt;
  logic wr_cur;
  logic wr_gain;
  logic [2:0] mid_in;
  logic [2:0] sum_in;
  logic [16:0] step_len;
  logic [16:0] pre_reg;
  logic [7:0] phase_reg;
  logic [28:0] shuf_cnt_reg;
  logic [1:0] rot_reg;
  logic pattern_mode;
  logic shuffle_on;
  logic hold;
  logic off;
  logic [7:0] amp [3];
  logic [2:0] led_next;
  logic [2:0] led_reg;

  // Synchronise clock, data and strap pins
  assign pin_raw = {addr_sel, link.sda, link.scl};
  for (genvar i = 0; i < 3; i++) begin : g_sync
    asl_sync #(.RST_VAL(1'b1)) u_sync (
      .clock(clock),
      .rst_n(rst_n),
      .d(pin_raw[i]),
      .q(pin_s[i])
    );
  end
  assign scl_s = pin_s[0];
  assign sda_s = pin_s[1];
  assign adr_s = pin_s[2];

  // Previous samples for edge and condition detection
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      scl_prev_reg <= 1'b1;
      sda_prev_reg <= 1'b1;
    end else begin
      scl_prev_reg <= scl_s;
      sda_prev_reg <= sda_s;
    end
  end

  // Line conditions and clock edges
  assign start_det = scl_s & scl_prev_reg & sda_prev_reg & ~sda_s;
  assign stop_det = scl_s & scl_prev_reg & ~sda_prev_reg & sda_s;
  assign scl_rise = scl_s & ~scl_prev_reg;
  assign scl_fall = ~scl_s & scl_prev_reg;
  assign addr_match = shift_reg == {asl_pkg::ADDR_HI, adr_s, asl_pkg::ADDR_WRITE};
  assign commit = (state_reg == asl_pkg::DS_DATA) & scl_fall & (bit_reg == asl_pkg::BYTE_BITS);

  // Slave sequencer: shift on rise, decide and acknowledge on the eighth fall
  always_comb begin
    state_next = state_reg;
    bit_next = bit_reg;
    shift_next = shift_reg;
    oe_next = oe_reg;
    if (start_det) begin
      state_next = asl_pkg::DS_ADDR;
      bit_next = 4'h0;
      oe_next = 1'b0;
    end else if (stop_det) begin
      state_next = asl_pkg::DS_IDLE;
      oe_next = 1'b0;
    end else begin
      unique case (state_reg)
        asl_pkg::DS_ADDR, asl_pkg::DS_DATA: begin
          if (scl_rise && bit_reg != asl_pkg::BYTE_BITS) begin
            shift_next = {shift_reg[6:0], sda_s};
            bit_next = bit_reg + 4'h1;
          end else if (scl_fall && bit_reg == asl_pkg::BYTE_BITS) begin
            if (state_reg == asl_pkg::DS_DATA) begin
              state_next = asl_pkg::DS_DACK;
              oe_next = 1'b1;
            end else if (addr_match) begin
              state_next = asl_pkg::DS_AACK;
              oe_next = 1'b1;
            end else begin
              state_next = asl_pkg::DS_SKIP;
            end
          end
        end
        asl_pkg::DS_AACK, asl_pkg::DS_DACK: begin
          if (scl_fall) begin
            state_next = asl_pkg::DS_DATA;
            bit_next = 4'h0;
            oe_next = 1'b0;
          end
        end
        asl_pkg::DS_IDLE, asl_pkg::DS_SKIP: begin
          state_next = state_reg;
        end
        default: begin
          state_next = asl_pkg::DS_IDLE;
        end
      endcase
    end
  end

  // Sequencer registers
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= asl_pkg::DS_IDLE;
      bit_reg <= 4'h0;
      shift_reg <= 8'h00;
      oe_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      bit_reg <= bit_next;
      shift_reg <= shift_next;
      oe_reg <= oe_next;
    end
  end
  assign link.dev_sda_o = 1'b0;
  assign link.dev_sda_oe = oe_reg;

  // Byte decode: selector picks the register, unused selectors drop the byte
  assign wr_mode = commit & (shift_reg[7:5] == asl_pkg::SEL_MODE);
  assign wr_freq = commit & (shift_reg[7:5] == asl_pkg::SEL_FREQ);
  assign wr_patt = commit & (shift_reg[7:5] == asl_pkg::SEL_PATT);
  assign wr_cur = commit & (shift_reg[7:6] == asl_pkg::SEL_CUR);
  assign wr_gain = commit & (shift_reg[7:6] == asl_pkg::SEL_GAIN);
  // Undefined high gain codes saturate at the top defined code
  assign mid_in = shift_reg[asl_pkg::GAIN_MID_LSB +: 3];
  assign sum_in = shift_reg[asl_pkg::GAIN_SUM_LSB +: 3];

  // Control fields; reserved positions are never stored
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      mode_reg <= asl_pkg::MODE_RST;
      pwm_sel_reg <= asl_pkg::PWM_RST;
      hpf_reg <= asl_pkg::HPF_RST;
      patt_reg <= asl_pkg::PATT_RST;
      cur_reg <= asl_pkg::CUR_RST;
      mid_reg <= asl_pkg::MID_RST;
      sum_reg <= asl_pkg::SUM_RST;
    end else begin
      if (wr_mode) mode_reg <= shift_reg[2:0];
      if (wr_freq) pwm_sel_reg <= shift_reg[asl_pkg::FREQ_PWM_LSB +: 2];
      if (wr_freq) hpf_reg <= shift_reg[asl_pkg::FREQ_HPF_LSB +: 2];
      if (wr_patt) patt_reg <= shift_reg[3:0];
      if (wr_cur) cur_reg <= shift_reg[asl_pkg::CUR_LSB +: 6];
      if (wr_gain) mid_reg <= (mid_in > asl_pkg::MID_MAX) ? asl_pkg::MID_MAX : mid_in;
      if (wr_gain) sum_reg <= (sum_in > asl_pkg::SUM_MAX) ? asl_pkg::SUM_MAX : sum_in;
    end
  end

  // Mode decode
  assign pattern_mode = patt_reg[asl_pkg::PATT_SRC_BIT];
  assign shuffle_on = mode_reg[asl_pkg::MODE_SHUF_BIT] & ~pattern_mode;
  assign hold = mode_reg[asl_pkg::MODE_RST_BIT];
  assign off = mode_reg[asl_pkg::MODE_SD_BIT] | hold;
  assign step_len = (pwm_sel_reg == 2'h0) ? STEP_F :
                    (pwm_sel_reg == 2'h1) ? STEP_60 :
                    (pwm_sel_reg == 2'h2) ? STEP_7 : STEP_4;

  // Shared PWM timebase: prescaler then 256-step phase
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      pre_reg <= 17'h00000;
      phase_reg <= 8'h00;
    end else if (hold) begin
      pre_reg <= 17'h00000;
      phase_reg <= 8'h00;
    end else if (pre_reg >= step_len - 17'h00001) begin
      pre_reg <= 17'h00000;
      phase_reg <= phase_reg + 8'h01;
    end else begin
      pre_reg <= pre_reg + 17'h00001;
    end
  end

  // Band randomizer: rotate band assignment at every interval
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      shuf_cnt_reg <= 29'h0000000;
      rot_reg <= 2'h0;
    end else if (!shuffle_on || hold) begin
      shuf_cnt_reg <= 29'h0000000;
      rot_reg <= 2'h0;
    end else if (shuf_cnt_reg >= SHUF_LAST) begin
      shuf_cnt_reg <= 29'h0000000;
      rot_reg <= (rot_reg == 2'h2) ? 2'h0 : rot_reg + 2'h1;
    end else begin
      shuf_cnt_reg <= shuf_cnt_reg + 29'h0000001;
    end
  end

  // Per-output duty selection
  assign amp[0] = low_band_amp;
  assign amp[1] = mid_band_amp;
  assign amp[2] = high_band_amp;
  for (genvar i = 0; i < 3; i++) begin : g_led
    logic [7:0] duty;
    assign duty = amp[band_for(2'(i), rot_reg)];
    assign led_next[i] = ~off & (pattern_mode ? patt_reg[asl_pkg::PATT_FORCE_LSB + i]
                                              : (phase_reg < duty));
  end

  // Output flops
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      led_reg <= 3'h0;
    end else begin
      led_reg <= led_next;
    end
  end
  assign first_color_output = led_reg[0];
  assign second_color_output = led_reg[1];
  assign third_color_output = led_reg[2];
  assign device_shutdown = mode_reg[asl_pkg::MODE_SD_BIT];
  assign core_reset_hold = hold;
  assign highpass_cutoff_field = hpf_reg;
  assign midband_gain_field = mid_reg;
  assign input_sum_gain_field = sum_reg;
  assign led_current_field = cur_reg;
endmodule

// ---- asl_pkg.sv ----
// Shared constants and types for the audio sync LED controller and its host.
// Assumes both ends run from one 125 MHz clock with an active-low async reset.
package asl_pkg;
  // System clock
  localparam int CLK_HZ = 125_000_000;
  localparam int CLK_PERIOD_NS = 8;
  localparam int MS_PER_S = 1000;
  // Serial clock period at the fastest rate; quarter period rounded up to cycles
  localparam int SCL_PERIOD_NS = 2500;
  localparam int SCL_QUARTER_CYC = (SCL_PERIOD_NS / 4 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SCL_QW = 7;
  localparam logic [3:0] BYTE_BITS = 4'h8;
  // PWM rates in Hz and duty resolution
  localparam int PWM_HZ_FAST = 15000;
  localparam int PWM_HZ_60 = 60;
  localparam int PWM_HZ_7 = 7;
  localparam int PWM_HZ_4 = 4;
  localparam int PWM_STEPS = 256;
  localparam int PWM_STEP_W = 17;
  // Band shuffle interval
  localparam int SHUFFLE_MS = 3200;
  localparam int SHUFFLE_W = 29;
  // Slave address: fixed upper six bits, strap bit, write direction bit
  localparam logic [5:0] ADDR_HI = 6'h3d;
  localparam logic ADDR_WRITE = 1'b0;
  // Data byte selectors in the upper bits
  localparam logic [2:0] SEL_MODE = 3'h0;
  localparam logic [2:0] SEL_FREQ = 3'h2;
  localparam logic [2:0] SEL_PATT = 3'h3;
  localparam logic [1:0] SEL_CUR = 2'h2;
  localparam logic [1:0] SEL_GAIN = 2'h3;
  // Field positions inside a data byte
  localparam int MODE_SD_BIT = 0;
  localparam int MODE_RST_BIT = 1;
  localparam int MODE_SHUF_BIT = 2;
  localparam int FREQ_PWM_LSB = 0;
  localparam int FREQ_HPF_LSB = 3;
  localparam int PATT_SRC_BIT = 0;
  localparam int PATT_FORCE_LSB = 1;
  localparam int CUR_LSB = 0;
  localparam int GAIN_MID_LSB = 0;
  localparam int GAIN_SUM_LSB = 3;
  // Reset values
  localparam logic [2:0] MODE_RST = 3'h5;
  localparam logic [1:0] PWM_RST = 2'h0;
  localparam logic [1:0] HPF_RST = 2'h2;
  localparam logic [3:0] PATT_RST = 4'h0;
  localparam logic [5:0] CUR_RST = 6'h2a;
  localparam logic [2:0] MID_RST = 3'h2;
  localparam logic [2:0] SUM_RST = 3'h2;
  // Highest defined gain codes
  localparam logic [2:0] MID_MAX = 3'h4;
  localparam logic [2:0] SUM_MAX = 3'h6;
  // Host command registers
  localparam int HOST_AW = 4;
  localparam logic [3:0] HOST_SEND_OFS = 4'h0;
  localparam logic [3:0] HOST_STAT_OFS = 4'h4;
  localparam int SEND_SEL_BIT = 16;
  localparam int SEND_TWO_BIT = 17;
  // State machines
  typedef enum logic [2:0] {
    DS_IDLE = 3'h0, DS_ADDR = 3'h1, DS_AACK = 3'h2,
    DS_DATA = 3'h3, DS_DACK = 3'h4, DS_SKIP = 3'h5
  } asl_dev_state_e;
  typedef enum logic [2:0] {
    HS_IDLE = 3'h0, HS_START = 3'h1, HS_BIT = 3'h2, HS_ACK = 3'h3, HS_STOP = 3'h4
  } asl_host_state_e;
endpackage

// ---- asl_link_if.sv ----
// Two-wire serial link between the host end and the LED controller end.
// Assumes an external pull-up: the data wire is low while any enabled driver drives low.
interface asl_link_if;
  logic scl;
  logic host_sda_o;
  logic host_sda_oe;
  logic dev_sda_o;
  logic dev_sda_oe;
  logic sda;
  // Open-drain resolution of the data wire
  assign sda = ~((host_sda_oe & ~host_sda_o) | (dev_sda_oe & ~dev_sda_o));
  modport host (output scl, output host_sda_o, output host_sda_oe, input sda);
  modport dev (input scl, input sda, output dev_sda_o, output dev_sda_oe);
endinterface

// ---- asl_sync.sv ----
// Two-stage synchroniser for one level from outside the clock domain.
// Assumes the input is a slow level; the idle value is set by RST_VAL.
module asl_sync #(
  parameter logic RST_VAL = 1'b1
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic d,
  output logic q
);
  logic meta_reg;
  logic stable_reg;
  // First stage feeds only the second
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      meta_reg <= RST_VAL;
      stable_reg <= RST_VAL;
    end else begin
      meta_reg <= d;
      stable_reg <= meta_reg;
    end
  end
  assign q = stable_reg;
endmodule

// ---- asl_led_host.sv ----
// Host end: drives the serial clock and writes one or two bytes per transfer.
// Assumes software on a plain strobe port; read data appear one cycle after the strobe.
module asl_led_host (
  input wire logic clock,
  input wire logic rst_n,
  asl_link_if.host link,
  input wire logic [3:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata
);
  localparam logic [6:0] Q_LAST = 7'(asl_pkg::SCL_QUARTER_CYC - 1);
  asl_pkg::asl_host_state_e state_reg, state_next;
  logic [6:0] qcnt_reg;
  logic [1:0] q_reg, q_next;
  logic [2:0] bit_reg, bit_next;
  logic [7:0] shift_reg, shift_next;
  logic [15:0] queue_reg, queue_next;
  logic [1:0] left_reg, left_next;
  logic scl_reg, scl_next;
  logic oe_reg, oe_next;
  logic ack_reg, ack_next;
  logic nack_reg, nack_next;
  logic done_reg, done_next;
  logic [31:0] rdata_reg;
  logic sda_s;
  logic tick;
  logic send_go;
  logic busy;

  asl_sync #(.RST_VAL(1'b1)) u_sda_sync (
    .clock(clock),
    .rst_n(rst_n),
    .d(link.sda),
    .q(sda_s)
  );

  // Command decode and quarter-period tick
  assign busy = state_reg != asl_pkg::HS_IDLE;
  assign send_go = reg_wr & (reg_addr == asl_pkg::HOST_SEND_OFS) & ~busy;
  assign tick = qcnt_reg == Q_LAST;

  // Bit sequencer, four quarters per serial clock period
  always_comb begin
    state_next = state_reg;
    q_next = q_reg;
    bit_next = bit_reg;
    shift_next = shift_reg;
    queue_next = queue_reg;
    left_next = left_reg;
    scl_next = scl_reg;
    oe_next = oe_reg;
    ack_next = ack_reg;
    nack_next = nack_reg;
    done_next = done_reg;
    if (send_go) begin
      state_next = asl_pkg::HS_START;
      q_next = 2'h0;
      bit_next = 3'h0;
      shift_next = {asl_pkg::ADDR_HI, reg_wdata[asl_pkg::SEND_SEL_BIT], asl_pkg::ADDR_WRITE};
      queue_next = reg_wdata[15:0];
      left_next = reg_wdata[asl_pkg::SEND_TWO_BIT] ? 2'h2 : 2'h1;
      nack_next = 1'b0;
      done_next = 1'b0;
    end else if (tick) begin
      q_next = q_reg + 2'h1;
      unique case (state_reg)
        asl_pkg::HS_IDLE: begin
          q_next = 2'h0;
        end
        asl_pkg::HS_START: begin
          if (q_reg == 2'h0) oe_next = 1'b1;
          if (q_reg == 2'h2) scl_next = 1'b0;
          if (q_reg == 2'h3) state_next = asl_pkg::HS_BIT;
        end
        asl_pkg::HS_BIT: begin
          if (q_reg == 2'h0) oe_next = ~shift_reg[7];
          if (q_reg == 2'h1) scl_next = 1'b1;
          if (q_reg == 2'h3) begin
            scl_next = 1'b0;
            shift_next = {shift_reg[6:0], 1'b0};
            bit_next = bit_reg + 3'h1;
            if (bit_reg == 3'h7) state_next = asl_pkg::HS_ACK;
          end
        end
        asl_pkg::HS_ACK: begin
          if (q_reg == 2'h0) oe_next = 1'b0;
          if (q_reg == 2'h1) scl_next = 1'b1;
          if (q_reg == 2'h2) ack_next = ~sda_s;
          if (q_reg == 2'h3) begin
            scl_next = 1'b0;
            if (!ack_reg) begin
              nack_next = 1'b1;
              state_next = asl_pkg::HS_STOP;
            end else if (left_reg == 2'h0) begin
              state_next = asl_pkg::HS_STOP;
            end else begin
              shift_next = queue_reg[7:0];
              queue_next = {8'h00, queue_reg[15:8]};
              left_next = left_reg - 2'h1;
              state_next = asl_pkg::HS_BIT;
            end
          end
        end
        asl_pkg::HS_STOP: begin
          if (q_reg == 2'h0) oe_next = 1'b1;
          if (q_reg == 2'h1) scl_next = 1'b1;
          if (q_reg == 2'h2) oe_next = 1'b0;
          if (q_reg == 2'h3) begin
            state_next = asl_pkg::HS_IDLE;
            done_next = 1'b1;
          end
        end
        default: begin
          state_next = asl_pkg::HS_IDLE;
        end
      endcase
    end
  end

  // Sequencer registers
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= asl_pkg::HS_IDLE;
      qcnt_reg <= 7'h00;
      q_reg <= 2'h0;
      bit_reg <= 3'h0;
      shift_reg <= 8'h00;
      queue_reg <= 16'h0000;
      left_reg <= 2'h0;
      scl_reg <= 1'b1;
      oe_reg <= 1'b0;
      ack_reg <= 1'b0;
      nack_reg <= 1'b0;
      done_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      qcnt_reg <= (send_go || tick) ? 7'h00 : qcnt_reg + 7'h01;
      q_reg <= q_next;
      bit_reg <= bit_next;
      shift_reg <= shift_next;
      queue_reg <= queue_next;
      left_reg <= left_next;
      scl_reg <= scl_next;
      oe_reg <= oe_next;
      ack_reg <= ack_next;
      nack_reg <= nack_next;
      done_reg <= done_next;
    end
  end

  // Status read, zero for any other offset
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rdata_reg <= 32'h00000000;
    end else begin
      rdata_reg <= (reg_rd && reg_addr == asl_pkg::HOST_STAT_OFS) ?
                   {29'h0000000, done_reg, nack_reg, busy} : 32'h00000000;
    end
  end
  assign reg_rdata = rdata_reg;
  assign link.scl = scl_reg;
  assign link.host_sda_o = 1'b0;
  assign link.host_sda_oe = oe_reg;
endmodule

// ---- asl_link_checker.sv ----
// Checker for the two-wire link between the host end and the LED end.
// Assumes it sees the link signals on the system clock with the async reset.
module asl_link_checker (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic scl,
  input wire logic host_sda_oe,
  input wire logic dev_sda_oe,
  input wire logic sda
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);
  logic scl_q;
  logic [3:0] rises;
  // Count clock rises since a start or since the last acknowledge release
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      scl_q <= 1'b1;
      rises <= 4'h0;
    end else begin
      scl_q <= scl;
      if (($fell(sda) && scl) || $fell(dev_sda_oe)) rises <= 4'h0;
      else if (scl && !scl_q) rises <= rises + 4'h1;
    end
  end
  // Master must have let go of data while the ninth clock pulse is high
  a_ack_released: assert property (scl && scl_q && rises == 4'h9 |-> !host_sda_oe)
    else $error("master holds data during acknowledge");
  a_ack_after_byte: assert property ($rose(dev_sda_oe) |-> !scl && rises == 4'h8)
    else $error("acknowledge not after eight bits");
  a_ack_release: assert property ($fell(dev_sda_oe) |-> !scl && rises == 4'h9)
    else $error("acknowledge released at wrong time");
  a_ack_length: assert property ($rose(dev_sda_oe) |-> ##[305:330] $fell(dev_sda_oe))
    else $error("acknowledge length wrong");
  a_bits_stable: assert property ($rose(scl) |-> $stable(sda) [*8])
    else $error("data moved after clock rise");
  a_low_bounded: assert property ($fell(scl) |-> ##[150:240] $rose(scl))
    else $error("clock low phase wrong");
  a_start_then_low: assert property ($fell(sda) && scl |-> ##[150:165] $fell(scl))
    else $error("start not followed by clock fall");
  a_stop_idle: assert property ($rose(sda) && scl && $past(scl) |-> (scl && sda) [*8])
    else $error("stop not followed by idle");
  c_start: cover property ($fell(sda) && scl);
  c_ack: cover property ($fell(dev_sda_oe));
  c_nack: cover property (rises == 4'h9 && scl && sda);
endmodule

// ---- audio_sync_led_pwm_ctrl_tb.sv ----
// Testbench: host end and LED end joined by one link, driven through the host register port.
// Assumes short PWM steps and shuffle interval so every timebase fits a few thousand cycles.
module audio_sync_led_pwm_ctrl_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int STEP [4] = '{2, 3, 4, 5};
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic [3:0] reg_addr = 4'h0;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [31:0] reg_rdata;
  logic addr_sel = 1'b0;
  logic [7:0] amp [3] = '{8'h00, 8'h00, 8'h00};
  logic [2:0] led;
  logic sd, rh;
  logic [1:0] hpf;
  logic [2:0] mid, sum;
  logic [5:0] cur;
  int fails = 0;
  int n_checks = 0;
  int cnt [3];
  integer seed = 32'hf62da5ca;
  asl_link_if link ();
  asl_led_host asl_led_host_inst (.clock(clock), .rst_n(rst_n), .link(link),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata));
  asl_led_dev #(.PWM_STEP_FAST(STEP[0]), .PWM_STEP_60(STEP[1]), .PWM_STEP_7(STEP[2]),
    .PWM_STEP_4(STEP[3]), .SHUFFLE_CYC(512)) asl_led_dev_inst (.clock(clock),
    .rst_n(rst_n), .link(link), .addr_sel(addr_sel), .low_band_amp(amp[0]),
    .mid_band_amp(amp[1]), .high_band_amp(amp[2]), .first_color_output(led[0]),
    .second_color_output(led[1]), .third_color_output(led[2]), .device_shutdown(sd),
    .core_reset_hold(rh), .highpass_cutoff_field(hpf), .midband_gain_field(mid),
    .input_sum_gain_field(sum), .led_current_field(cur));
  asl_link_checker asl_link_checker_inst (.clock(clock), .rst_n(rst_n), .scl(link.scl),
    .host_sda_oe(link.host_sda_oe), .dev_sda_oe(link.dev_sda_oe), .sda(link.sda));
  // Clock source
  initial begin
    forever #4 clock = ~clock;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_checks++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED at %0t: %s got %0h expected %0h", $time, what, got, exp);
    end
  endtask
  task automatic report_and_stop;
    if (fails == 0 && n_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic rd(input logic [3:0] a, output logic [31:0] d);
    @(posedge clock);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clock);
    reg_rd <= 1'b0;
    @(negedge clock);
    d = reg_rdata;
  endtask
  // One transfer of one or two bytes, then poll status until idle
  task automatic send(input logic x, input logic [7:0] b0, input logic [7:0] b1,
                      input logic two, input logic [2:0] st);
    logic [31:0] d;
    int n;
    @(posedge clock);
    reg_addr <= asl_pkg::HOST_SEND_OFS;
    reg_wdata <= {14'h0, two, x, b1, b0};
    reg_wr <= 1'b1;
    @(posedge clock);
    reg_wr <= 1'b0;
    n = 0;
    do begin
      rd(asl_pkg::HOST_STAT_OFS, d);
      n++;
    end while (d[0] !== 1'b0 && n < 20000);
    chk(d, {29'h0, st}, "status");
  endtask
  // Count high cycles of each output over a window
  task automatic measure(input int n);
    cnt = '{0, 0, 0};
    repeat (n) begin
      @(negedge clock);
      // An unknown level spoils the count
      for (int k = 0; k < 3; k++) begin
        cnt[k] += (led[k] === 1'b1) ? 1 : (led[k] === 1'b0) ? 0 : 100000;
      end
    end
  endtask
  function automatic logic [2:0] sat(input logic [2:0] c, input logic [2:0] m);
    return (c > m) ? m : c;
  endfunction
  // Watchdog
  initial begin
    repeat (110000) @(posedge clock);
    fails++;
    report_and_stop();
  end
  // Main sequence
  initial begin
    logic [31:0] d;
    logic [2:0] g, h, pv;
    logic [1:0] f;
    logic [5:0] cr;
    int s;
    repeat (8) @(posedge clock);
    rst_n <= 1'b1;
    repeat (4) @(posedge clock);
    chk(32'({sd, rh, hpf, mid, sum, cur}), 32'({2'b10, asl_pkg::HPF_RST, asl_pkg::MID_RST,
      asl_pkg::SUM_RST, asl_pkg::CUR_RST}), "reset");
    rd(4'h8, d);
    chk(d, 32'h0, "unmapped");
    for (int i = 0; i < 3; i++) begin
      @(posedge clock);
      addr_sel <= i[0];
      send(i[1] ^ i[0], 8'h18, 8'h00, 1'b0, i[1] ? 3'h6 : 3'h4);
    end
    chk(32'({sd, rh}), 32'h0, "mode");
    for (int i = 0; i < 2; i++) begin
      g = 3'($random(seed));
      h = 3'($random(seed));
      f = 2'($random(seed));
      if (i == 0) {g, h} = 6'h3f;
      send(addr_sel, {2'b11, h, g}, {3'b010, f, 3'h4}, 1'b1, 3'h4);
      chk(32'({hpf, mid, sum}), 32'({f, sat(g, asl_pkg::MID_MAX),
        sat(h, asl_pkg::SUM_MAX)}), "fields");
    end
    // Timebase settles within one step of the commit, so measure at once
    for (int r = 0; r < 4; r++) begin
      @(posedge clock);
      for (int k = 0; k < 3; k++) amp[k] <= (r == 0 && k == 0) ? 8'hff : 8'($random(seed));
      send(addr_sel, {6'h10, r[1:0]}, 8'h00, 1'b0, 3'h4);
      measure(256 * STEP[r]);
      for (int k = 0; k < 3; k++) chk(cnt[k], amp[k] * STEP[r], "duty");
    end
    send(addr_sel, 8'h04, 8'h40, 1'b1, 3'h4);
    measure(1536);
    s = 2 * (int'(amp[0]) + int'(amp[1]) + int'(amp[2]));
    for (int k = 0; k < 3; k++) chk(cnt[k], s, "shuffle");
    for (int i = 0; i < 2; i++) begin
      pv = (i == 0) ? 3'h7 : 3'h2;
      send(addr_sel, {4'h6, pv, 1'b1}, 8'h00, 1'b0, 3'h4);
      measure(512);
      for (int k = 0; k < 3; k++) chk(cnt[k], pv[k] ? 512 : 0, "pattern");
    end
    // Current field write, then soft reset must blank a lit pattern
    cr = 6'($random(seed));
    send(addr_sel, {2'b10, cr}, 8'h02, 1'b1, 3'h4);
    chk(32'({sd, rh, cur}), 32'({2'b01, cr}), "current");
    measure(64);
    for (int k = 0; k < 3; k++) chk(cnt[k], 0, "hold");
    report_and_stop();
  end
endmodule
